// ==== verilog/pbec_capture.sv ====
// Purpose: Peripheral bus error capture registers behind an index/value pair
// Assumes: One error report per master per cycle, master index order 0..2
// Notes: Records stay until software writes zero to their type field in the status word
//
// Notes on behaviour
// - On a bus error capture the full 32-bit failing address into a read-only register; the code skips this while that master still holds a record.
// - DMA master error type sits in status bits 0:2, the most significant.
// - Type codes: 000 none, 100 protection, 110 input error, 111 timeout.
// - Status bit 3 shows DMA direction, 1 read, 0 write.
// - Instruction cache error type sits in status bits 6:8.
// - Status bit 9 shows instruction cache direction, 1 read, 0 write.
// - Data side error type sits in status bits 12:14.
// - Status bits 4:5 and 10:11 are reserved and always read zero.
`timescale 1ns/10ps
`include "pbec_consts.svh"

module pbec_capture #(
    parameter int ADDR_W = 32,
    parameter int IDX_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire pbec_pkg::pbec_err_t dma_err,
    input wire pbec_pkg::pbec_err_t icache_err,
    input wire pbec_pkg::pbec_err_t data_err,
    input wire logic [ADDR_W-1:0] err_addr,
    input wire logic index_wr,
    input wire logic [IDX_W-1:0] index_wdata,
    input wire logic value_wr,
    input wire logic value_rd,
    input wire logic [31:0] value_wdata,
    output logic [31:0] value_rdata,
    output logic value_ack
);
    // Reports enter one slice per master; an accepted one loads the shared
    // address register. Records are sticky because software reaches them
    // slowly through the indirect index/value pair. The price: a second
    // error on a master that still holds a record is dropped, address and
    // all, so software should clear promptly. Masters are not prioritised;
    // the one address register simply follows whichever report was taken.

    // Per-master records, in master order: dma, instruction cache, data side
    pbec_pkg::pbec_rec_t rec [3];
    pbec_pkg::pbec_err_t ev [3];
    logic [2:0] accept;
    logic any_new;
    logic clear_status;

    // Shared address capture
    logic [ADDR_W-1:0] bus_error_address_reg;
    logic [ADDR_W-1:0] next_bus_error_address_reg;

    // Index/value port state
    logic [IDX_W-1:0] config_index_port;
    logic [IDX_W-1:0] next_config_index_port;
    logic hit_address;
    logic hit_status;
    logic [31:0] bus_error_status_first_reg;
    logic [31:0] read_word;
    logic [31:0] next_value_rdata;
    logic next_value_ack;

    // Type field of each master inside a written status word
    localparam int TYPE_MSB [3] = '{`PBEC_DMA_TYPE_MSB, `PBEC_IC_TYPE_MSB, `PBEC_DS_TYPE_MSB};

    // Gather the report ports so one loop serves all masters
    assign ev[0] = dma_err;
    assign ev[1] = icache_err;
    assign ev[2] = data_err;

    // Index decode; only the two mapped indices answer with data
    always_comb begin
        hit_address = 1'b0;
        hit_status = 1'b0;
        if (config_index_port == IDX_W'(`PBEC_IDX_ADDRESS)) begin
            hit_address = 1'b1;
        end else if (config_index_port == IDX_W'(`PBEC_IDX_STATUS)) begin
            hit_status = 1'b1;
        end
    end

    // A status write is the only way software releases a held record
    assign clear_status = value_wr && hit_status;

    // One capture slice per master
    for (genvar m = 0; m < 3; m++) begin : g_master
        pbec_pkg::pbec_rec_t held;
        pbec_pkg::pbec_rec_t next_held;
        logic report_live;
        logic release_now;
        logic take;

        // A report counts only when flagged and carrying a real type
        assign report_live = ev[m].valid && ev[m].err_type != `PBEC_ET_NONE;

        // Zero in this master's type field releases; nonzero keeps the record
        assign release_now = clear_status && value_wdata[TYPE_MSB[m] -: 3] == 3'h0;

        // Next record; a capture wins over a release in the same cycle
        always_comb begin
            next_held = held;
            take = 1'b0;
            // Release first so a same-cycle capture overrides it
            if (release_now) begin
                next_held.err_type = `PBEC_ET_NONE;
                next_held.is_read = 1'b0;
            end
            // Full record drops new errors so an unread one is not lost
            if (report_live && (held.err_type == `PBEC_ET_NONE || release_now)) begin
                next_held.err_type = ev[m].err_type;
                next_held.is_read = ev[m].is_read;
                take = 1'b1;
            end
        end

        // Record register
        always_ff @(posedge core_clk) begin
            if (rst) begin
                held <= '0;
            end else begin
                held <= next_held;
            end
        end

        // Hand the slice out to the shared logic
        assign rec[m] = held;
        assign accept[m] = take;
    end

    // Any accepted report carries the address along
    assign any_new = |accept;

    // Next address; a dropped report leaves the held address alone
    always_comb begin
        next_bus_error_address_reg = bus_error_address_reg;
        if (any_new) begin
            next_bus_error_address_reg = err_addr;
        end
    end

    // Address register; read-only, no software write path reaches it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus_error_address_reg <= '0;
        end else begin
            bus_error_address_reg <= next_bus_error_address_reg;
        end
    end

    // Status word; data side direction also kept, at bit 15
    // Reserved bits are forced low so software may test whole words
    always_comb begin
        bus_error_status_first_reg = `PBEC_RESET_WORD;
        bus_error_status_first_reg[`PBEC_DMA_TYPE_MSB -: 3] = rec[0].err_type;
        bus_error_status_first_reg[`PBEC_DMA_DIR_BIT] = rec[0].is_read;
        bus_error_status_first_reg[`PBEC_IC_TYPE_MSB -: 3] = rec[1].err_type;
        bus_error_status_first_reg[`PBEC_IC_DIR_BIT] = rec[1].is_read;
        bus_error_status_first_reg[`PBEC_DS_TYPE_MSB -: 3] = rec[2].err_type;
        bus_error_status_first_reg[`PBEC_DS_DIR_BIT] = rec[2].is_read;
    end

    // Next index; a new index is used from the cycle after its write
    always_comb begin
        next_config_index_port = config_index_port;
        if (index_wr) begin
            next_config_index_port = index_wdata;
        end
    end

    // Index register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            config_index_port <= '0;
        end else begin
            config_index_port <= next_config_index_port;
        end
    end

    // Read source; unmapped indices read as zero
    always_comb begin
        read_word = `PBEC_RESET_WORD;
        if (hit_address) begin
            read_word = 32'(bus_error_address_reg);
        end else if (hit_status) begin
            read_word = bus_error_status_first_reg;
        end
    end

    // Acknowledge every value access, read or write, one cycle later
    always_comb begin
        next_value_ack = value_rd || value_wr;
    end

    // Acknowledge register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            value_ack <= 1'b0;
        end else begin
            value_ack <= next_value_ack;
        end
    end

    // Next read data; zero outside a read so stale words never leak
    always_comb begin
        next_value_rdata = `PBEC_RESET_WORD;
        if (value_rd) begin
            next_value_rdata = read_word;
        end
    end

    // Read data register; outputs come straight from flip-flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            value_rdata <= '0;
        end else begin
            value_rdata <= next_value_rdata;
        end
    end

    // Limitation: a report with a reserved type code is stored as given;
    // the masters are trusted to send only the four defined codes.
endmodule

// ==== include/pbec_consts.svh ====
// Purpose: Offsets, field positions and codes of the bus error capture block
// Assumes: Indirect index/value access on the device control bus
// Notes: Big-endian bit numbering maps bit n to vector bit 31-n
`ifndef PBEC_CONSTS_SVH
`define PBEC_CONSTS_SVH

`define PBEC_IDX_ADDRESS 8'h20
`define PBEC_IDX_STATUS 8'h21
`define PBEC_DMA_TYPE_MSB 31
`define PBEC_DMA_DIR_BIT 28
`define PBEC_IC_TYPE_MSB 25
`define PBEC_IC_DIR_BIT 22
`define PBEC_DS_TYPE_MSB 19
`define PBEC_DS_DIR_BIT 16
`define PBEC_ET_NONE 3'h0
`define PBEC_ET_PROT 3'h4
`define PBEC_ET_INPUT 3'h6
`define PBEC_ET_TIMEOUT 3'h7
`define PBEC_RESET_WORD 32'h0000_0000

`endif

// ==== include/pbec_pkg.sv ====
// Purpose: Types shared by the bus error capture block
// Assumes: Nothing beyond the constants header
// Notes: Error report travels as one packed struct
package pbec_pkg;
    typedef struct packed {
        logic valid;
        logic [2:0] err_type;
        logic is_read;
    } pbec_err_t;

    typedef struct packed {
        logic [2:0] err_type;
        logic is_read;
    } pbec_rec_t;
endpackage

// ==== dv/pbec_capture_assertions.sv ====
// Purpose: Port checks for the bus error capture block
// Assumes: Index width 8
// Notes: Mirrors the index so a read's source is known
`timescale 1ns/10ps
module pbec_capture_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic index_wr,
    input wire logic [7:0] index_wdata,
    input wire logic value_wr,
    input wire logic value_rd,
    input wire logic [31:0] value_rdata,
    input wire logic value_ack
);
    logic [7:0] idx, rd_idx;
    logic rd_q;
    // Index mirror; rd_idx is the index a read used
    always_ff @(posedge core_clk) begin
        idx <= rst ? 8'h0 : (index_wr ? index_wdata : idx);
        rd_idx <= idx;
        rd_q <= value_rd & ~rst;
    end
    wire st = value_ack & rd_q & (rd_idx == 8'h21);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_ack_after_req: assert property ((value_rd | value_wr) |=> value_ack)
        else $error("ack missing");
    a_ack_has_cause: assert property (value_ack |-> $past(value_rd | value_wr))
        else $error("ack without request");
    a_rdata_idle_zero: assert property (!rd_q |-> value_rdata == 32'h0)
        else $error("read data outside read");
    a_unmapped_zero: assert property (rd_q && rd_idx[7:1] != 7'h10 |-> value_rdata == 32'h0)
        else $error("unmapped index not zero");
    a_reserved_zero: assert property (st |-> value_rdata[27:26] == 2'h0 && value_rdata[21:20] == 2'h0)
        else $error("reserved status bits set");
    a_dma_type_legal: assert property (st |-> value_rdata[31:29] inside {3'h0, 3'h4, 3'h6, 3'h7})
        else $error("dma type code reserved");
    a_ic_type_legal: assert property (st |-> value_rdata[25:23] inside {3'h0, 3'h4, 3'h6, 3'h7})
        else $error("icache type code reserved");
    a_ds_type_legal: assert property (st |-> value_rdata[19:17] inside {3'h0, 3'h4, 3'h6, 3'h7})
        else $error("data side type code reserved");
endmodule
bind pbec_capture pbec_capture_assertions chk (.core_clk, .rst, .index_wr, .index_wdata,
    .value_wr, .value_rd, .value_rdata, .value_ack);

// ==== dv/pbec_masters.sv ====
// Purpose: Bus masters raising error reports
// Assumes: report is called just after a rising edge
// Notes: Released lines carry inverted junk, not the last report
`timescale 1ns/10ps
module pbec_masters (
    input wire logic core_clk,
    output pbec_pkg::pbec_err_t err [3],
    output logic [31:0] err_addr
);
    initial err = '{default: '0};
    initial err_addr = 32'h0;
    // One-cycle report; junk after so a stale type must be ignored
    task automatic report(input int m, input logic [2:0] t, input logic rd, input logic [31:0] a);
        err[m] = {1'b1, t, rd};
        err_addr = a;
        @(posedge core_clk) #1;
        err[m] = {1'b0, ~t, ~rd};
        err_addr = ~a;
    endtask
endmodule

// ==== dv/pbec_capture_bench.sv ====
// Purpose: Register-level tests of the bus error capture block
// Assumes: Reset values zero, ack one cycle after a request
// Notes: Status expectations use the big-endian bit mapping
`timescale 1ns/10ps
module pbec_capture_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic index_wr = 1'b0, value_wr = 1'b0, value_rd = 1'b0, value_ack;
    logic [7:0] index_wdata = 8'h0;
    logic [31:0] value_wdata = 32'h0, value_rdata, err_addr;
    pbec_pkg::pbec_err_t errs [3];
    int error_cnt = 0, comparisons = 0;
    always #5 core_clk = ~core_clk;
    pbec_masters masters (.core_clk(core_clk), .err(errs), .err_addr(err_addr));
    pbec_capture uut (.core_clk(core_clk), .rst(rst), .dma_err(errs[0]), .icache_err(errs[1]),
        .data_err(errs[2]), .err_addr(err_addr), .index_wr(index_wr), .index_wdata(index_wdata),
        .value_wr(value_wr), .value_rd(value_rd), .value_wdata(value_wdata),
        .value_rdata(value_rdata), .value_ack(value_ack));
    task automatic print_verdict();
        $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Index, then value access; checks ack and read data
    task automatic acc(input logic [7:0] i, input logic wr, input logic [31:0] d, exp);
        index_wr = 1'b1;
        index_wdata = i;
        @(posedge core_clk) #1;
        {index_wr, value_wr, value_rd, value_wdata} = {1'b0, wr, ~wr, d};
        @(posedge core_clk) #1;
        {value_wr, value_rd} = 2'b00;
        comparisons++;
        if (value_ack !== 1'b1 || (!wr && value_rdata !== exp)) begin
            error_cnt++;
            $display("wrong value at %0t: %h %h", $time, value_rdata, exp);
        end
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        #1 rst = 1'b0;
        masters.report(0, 3'h4, 1'b1, 32'h1234_5678);
        acc(8'h20, 1'b0, 32'h0, 32'h1234_5678);
        masters.report(1, 3'h7, 1'b0, 32'h0bad_f00d);
        masters.report(2, 3'h6, 1'b1, 32'h0000_0004);
        masters.report(0, 3'h7, 1'b0, 32'h0000_0008);
        acc(8'h21, 1'b0, 32'h0, 32'h938d_0000);
        acc(8'h20, 1'b1, 32'hffff_ffff, 32'h0);
        acc(8'h20, 1'b0, 32'h0, 32'h0000_0004);
        acc(8'h21, 1'b1, 32'h0, 32'h0);
        acc(8'h21, 1'b0, 32'h0, 32'h0);
        acc(8'h22, 1'b0, 32'h0, 32'h0);
        // Status write keeps dma (field nonzero), frees the rest; errors land on it
        masters.report(0, 3'h4, 1'b1, 32'h0000_0010);
        fork
            acc(8'h21, 1'b1, 32'h8000_0000, 32'h0);
            begin
                @(posedge core_clk) #1;
                masters.report(0, 3'h7, 1'b0, 32'h0000_0020);
            end
            begin
                @(posedge core_clk) #1;
                masters.report(1, 3'h6, 1'b1, 32'h0000_0020);
            end
        join
        acc(8'h21, 1'b0, 32'h0, 32'h9340_0000);
        acc(8'h20, 1'b0, 32'h0, 32'h0000_0020);
        print_verdict();
    end
    // Watchdog well past the roughly 41 cycles of the tests
    initial begin
        #20000;
        error_cnt++;
        print_verdict();
    end
endmodule
